// ===== common/xmb_regs.vh
// constants for the external memory bus pin controller
`ifndef XMB_REGS_VH
`define XMB_REGS_VH
// ==========================================
// bank width codes
`define XMB_WIDTH_8          2'h0
`define XMB_WIDTH_16         2'h1
`define XMB_WIDTH_32         2'h2
// ==========================================
// request space codes
`define XMB_SPACE_BANK0      2'h0
`define XMB_SPACE_BANK1      2'h1
`define XMB_SPACE_PERIPH     2'h2
// ==========================================
// field positions and sizes
`define XMB_DATA_W           32
`define XMB_ADDR_W           24
`define XMB_LANE_ADDR1_BIT   1
`define XMB_LANE_ADDR2_BIT   2
`endif

// ===== rtl/xmb_bus_pins.v
// external memory bus pin controller
`timescale 1ns/1ns
`include "xmb_regs.vh"
module xmb_bus_pins (
    input  wire        mclk,
    input  wire        resetn,
    input  wire        reqValid,
    output reg         reqReady,
    input  wire        reqWrite,
    input  wire        reqFetch,
    input  wire [1:0]  reqSpace,
    input  wire [1:0]  reqSize,
    input  wire [23:0] reqAddr,
    input  wire [31:0] reqWdata,
    output reg         respValid,
    output reg  [31:0] respRdata,
    input  wire [1:0]  bank0Width,
    input  wire [1:0]  bank1Width,
    input  wire        ignore_hold_bit,
    input  wire        program_width_sel,
    input  wire        float_all_n,
    input  wire        holdReqN,
    input  wire        readyN,
    input  wire [31:0] dataIn,
    output reg  [31:0] dataOut,
    output reg         dataOe,
    output reg  [23:0] addrOut,
    output reg         addrOe,
    output reg         readWriteN,
    output reg         ctrlOe,
    output reg         peripheral_strobe_n,
    output reg         bank0_lane3_or_addr1,
    output reg         bank0_lane2_or_addr2,
    output reg         bank0_lane1_en_n,
    output reg         bank0_lane0_en_n,
    output reg         bank1_lane3_or_addr1,
    output reg         bank1_lane2_or_addr2,
    output reg         bank1_lane1_en_n,
    output reg         bank1_lane0_en_n,
    output reg         bus_hold_ack_n
);
    // ==========================================
    // states
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_ACC  = 4'h2;
    localparam [3:0] ST_HOLD = 4'h4;
    localparam [3:0] ST_GAP  = 4'h8;

    // ==========================================
    // pin synchronisers
    reg  [1:0]  holdSync;
    reg  [1:0]  floatSync;
    reg  [1:0]  readySync;
    reg  [1:0]  prgwSync;
    reg  [31:0] dataSync1;
    reg  [31:0] dataSync2;
    always @(posedge mclk) begin
        if (!resetn) begin
            holdSync  <= 2'h3;
            floatSync <= 2'h3;
            readySync <= 2'h3;
            prgwSync  <= 2'h0;
            dataSync1 <= 32'h0;
            dataSync2 <= 32'h0;
        end else begin
            holdSync  <= {holdSync[0], holdReqN};
            floatSync <= {floatSync[0], float_all_n};
            readySync <= {readySync[0], readyN};
            prgwSync  <= {prgwSync[0], program_width_sel};
            dataSync1 <= dataIn;
            dataSync2 <= dataSync1;
        end
    end
    wire holdWanted = ~holdSync[1] & ~ignore_hold_bit;
    wire floatAll   = ~floatSync[1];
    wire rdy        = ~readySync[1];

    // ==========================================
    // access registers
    reg  [3:0]  state;
    reg         curWrite;
    reg  [1:0]  curSpace;
    reg  [1:0]  curSize;
    reg  [23:0] curAddr;
    reg  [31:0] curWdata;
    reg         halfPhase;
    reg         splitFetch;
    reg  [15:0] lowHalf;

    function [1:0] effWidth;
        input [1:0] space;
        input [1:0] w0;
        input [1:0] w1;
        begin
            effWidth = (space == `XMB_SPACE_BANK1) ? w1 : w0;
        end
    endfunction

    wire [3:0] lanes0N;
    wire [3:0] lanes1N;
    wire [1:0] lowAddr = splitFetch ? {halfPhase, 1'b0} : curAddr[1:0];
    wire [1:0] effSize = splitFetch ? 2'h1 : curSize;
    // strobes only for the addressed bank
    // bank select
    // split fetch uses the half-width map: lane 3 pin carries the half select
    xmb_lane_map uLane0 (
        .bankWidth  (splitFetch ? `XMB_WIDTH_16 : bank0Width),
        .byteOffset (lowAddr),
        .accessSize (effSize),
        .selected   (curSpace == `XMB_SPACE_BANK0),
        .strobeN    (lanes0N)
    );
    xmb_lane_map uLane1 (
        .bankWidth  (splitFetch ? `XMB_WIDTH_16 : bank1Width),
        .byteOffset (lowAddr),
        .accessSize (effSize),
        .selected   (curSpace == `XMB_SPACE_BANK1),
        .strobeN    (lanes1N)
    );

    // ==========================================
    // sequencer
    always @(posedge mclk) begin
        if (!resetn) begin
            state      <= ST_IDLE;
            reqReady   <= 1'b0;
            respValid  <= 1'b0;
            respRdata  <= 32'h0;
            curWrite   <= 1'b0;
            curSpace   <= `XMB_SPACE_BANK0;
            curSize    <= 2'h2;
            curAddr    <= 24'h0;
            curWdata   <= 32'h0;
            halfPhase  <= 1'b0;
            splitFetch <= 1'b0;
            lowHalf    <= 16'h0;
            bus_hold_ack_n <= 1'b1;
        end else begin
            respValid <= 1'b0;
            reqReady  <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (holdWanted) begin
                        state <= ST_HOLD;
                    end else if (reqValid && !floatAll) begin
                        reqReady   <= 1'b1;
                        curWrite   <= reqWrite;
                        curSpace   <= reqSpace;
                        curSize    <= reqSize;
                        curAddr    <= reqAddr;
                        curWdata   <= reqWdata;
                        halfPhase  <= 1'b0;
                        splitFetch <= reqFetch & prgwSync[1] & ~reqWrite;
                        state      <= ST_ACC;
                    end
                end
                ST_ACC: begin
                    if (rdy) begin
                        if (splitFetch && !halfPhase) begin
                            lowHalf   <= dataSync2[15:0];
                            halfPhase <= 1'b1;
                        end else begin
                            respValid  <= ~curWrite;
                            respRdata  <= splitFetch ? {dataSync2[15:0], lowHalf} : dataSync2;
                            splitFetch <= 1'b0;
                            state      <= ST_GAP;
                        end
                    end
                end
                ST_HOLD: begin
                    if (holdWanted) begin
                        bus_hold_ack_n <= 1'b0;
                    end else begin
                        bus_hold_ack_n <= 1'b1;
                        state          <= ST_IDLE;
                    end
                end
                ST_GAP: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // registered pin outputs
    wire inAcc    = (state == ST_ACC);
    wire floating = floatAll | (state == ST_HOLD);
    always @(posedge mclk) begin
        if (!resetn) begin
            dataOut     <= 32'h0;
            dataOe      <= 1'b0;
            addrOut     <= 24'h0;
            addrOe      <= 1'b0;
            readWriteN  <= 1'b1;
            ctrlOe      <= 1'b0;
            peripheral_strobe_n  <= 1'b1;
            bank0_lane3_or_addr1 <= 1'b1;
            bank0_lane2_or_addr2 <= 1'b1;
            bank0_lane1_en_n     <= 1'b1;
            bank0_lane0_en_n     <= 1'b1;
            bank1_lane3_or_addr1 <= 1'b1;
            bank1_lane2_or_addr2 <= 1'b1;
            bank1_lane1_en_n     <= 1'b1;
            bank1_lane0_en_n     <= 1'b1;
        end else begin
            dataOe     <= ~floating & inAcc & curWrite;
            dataOut    <= curWdata;
            addrOe     <= ~floating;
            addrOut    <= {curAddr[23:2], lowAddr};
            ctrlOe     <= ~floating;
            readWriteN <= ~(inAcc & curWrite);
            peripheral_strobe_n  <= ~(inAcc & (curSpace == `XMB_SPACE_PERIPH));
            bank0_lane3_or_addr1 <= inAcc ? lanes0N[3] : 1'b1;
            bank0_lane2_or_addr2 <= inAcc ? lanes0N[2] : 1'b1;
            bank0_lane1_en_n     <= inAcc ? lanes0N[1] : 1'b1;
            bank0_lane0_en_n     <= inAcc ? lanes0N[0] : 1'b1;
            bank1_lane3_or_addr1 <= inAcc ? lanes1N[3] : 1'b1;
            bank1_lane2_or_addr2 <= inAcc ? lanes1N[2] : 1'b1;
            bank1_lane1_en_n     <= inAcc ? lanes1N[1] : 1'b1;
            bank1_lane0_en_n     <= inAcc ? lanes1N[0] : 1'b1;
        end
    end
endmodule

// ===== rtl/xmb_lane_map.v
// byte lane and strobe encoder for one memory bank
`timescale 1ns/1ns
`include "xmb_regs.vh"
module xmb_lane_map (
    input  wire [1:0] bankWidth,
    input  wire [1:0] byteOffset,
    input  wire [1:0] accessSize,
    input  wire       selected,
    output reg  [3:0] strobeN
);
    // accessSize: 0 byte, 1 halfword, 2 word
    always @* begin
        strobeN = 4'hf;
        if (selected) begin
            case (bankWidth)
                `XMB_WIDTH_32: begin
                    // bank lanes chosen by offset and size
                    case (accessSize)
                        2'h0: strobeN = ~(4'h1 << byteOffset);
                        2'h1: strobeN = byteOffset[1] ? 4'h3 : 4'hc;
                        default: strobeN = 4'h0;
                    endcase
                end
                `XMB_WIDTH_16: begin
                    // upper pin carries addr bit 1, lane 2 unused and idle
                    strobeN[3] = byteOffset[1];
                    strobeN[2] = 1'b1;
                    strobeN[1] = (accessSize == 2'h0) ? ~byteOffset[0] : 1'b0;
                    strobeN[0] = (accessSize == 2'h0) ? byteOffset[0] : 1'b0;
                end
                default: begin
                    // 8-bit: both upper pins carry addr bits 1 and 0
                    strobeN[3] = byteOffset[1];
                    strobeN[2] = byteOffset[0];
                    strobeN[1] = 1'b1;
                    strobeN[0] = 1'b0;
                end
            endcase
        end
    end
endmodule

// ===== test/xmb_bus_pins_chk.sv
// assertion checker for the external bus pin controller
`timescale 1ns/1ns
`include "xmb_regs.vh"
module xmb_bus_pins_chk (
    input logic       mclk,
    input logic       resetn,
    input logic       reqValid,
    input logic       reqReady,
    input logic       readyN,
    input logic       float_all_n,
    input logic       respValid,
    input logic       dataOe,
    input logic       addrOe,
    input logic       ctrlOe,
    input logic       readWriteN,
    input logic       peripheral_strobe_n,
    input logic       bank0_lane0_en_n,
    input logic       bank1_lane0_en_n,
    input logic       bus_hold_ack_n,
    input logic [1:0] bank0Width,
    input logic       bank0_lane2_or_addr2
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    rel_float_a: assert property ($rose(resetn) |-> !(ctrlOe || addrOe || dataOe))
        else $error("bus driven right after reset");
    float_all_a: assert property (!float_all_n [*5] |-> !(ctrlOe || addrOe || dataOe))
        else $error("bus driven under float-all");
    hold_float_a: assert property (!bus_hold_ack_n |-> !(ctrlOe || addrOe || dataOe))
        else $error("hold ack while bus driven");
    take_hold_a: assert property (reqReady |-> $past(reqValid) && bus_hold_ack_n)
        else $error("request taken without cause");
    data_dir_a: assert property (dataOe |-> !readWriteN)
        else $error("data driven outside a write");
    resp_dir_a: assert property (respValid |-> readWriteN)
        else $error("read answered while direction low");
    resp_ready_a: assert property (respValid |-> !$past(readyN, 3))
        else $error("read done without ready");
    strobe_excl_a: assert property (!peripheral_strobe_n |-> bank0_lane0_en_n && bank1_lane0_en_n)
        else $error("peripheral and bank strobes together");
    half_lane2_a: assert property (ctrlOe && bank0Width == `XMB_WIDTH_16 |-> bank0_lane2_or_addr2)
        else $error("lane 2 active at half width");
    cover property (respValid);
    cover property (!bus_hold_ack_n ##1 bus_hold_ack_n);
    cover property (!float_all_n [*5]);
endmodule
bind xmb_bus_pins xmb_bus_pins_chk i_chk (.*);

// ===== test/xmb_bus_pins_test.sv
// self-checking bench for the external bus pin controller
`timescale 1ns/1ns
module xmb_bus_pins_test;
    typedef struct packed {
        logic [1:0] wid, sp;
        logic wr, fe;
        logic [1:0] sz;
        logic [23:0] ad;
        logic [31:0] wd;
        logic [4:0] st;
    } xmb_row_t;
    logic mclk = 1'b0, resetn = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, reqFetch = 1'b0;
    logic [1:0] reqSpace = 2'h0, reqSize = 2'h2, bank0Width = 2'h2, bank1Width = 2'h2;
    logic [23:0] reqAddr = 24'h0, addrOut;
    logic [31:0] reqWdata = 32'h0, respRdata, dataIn, dataOut, rd;
    logic ignore_hold_bit = 1'b0, program_width_sel = 1'b0, float_all_n = 1'b1, holdReqN = 1'b1;
    logic [3:0] waitCyc = 4'h0;
    logic reqReady, respValid, readyN, dataOe, addrOe, readWriteN, ctrlOe, bus_hold_ack_n;
    logic peripheral_strobe_n, bank0_lane3_or_addr1, bank0_lane2_or_addr2, bank0_lane1_en_n, bank0_lane0_en_n;
    logic bank1_lane3_or_addr1, bank1_lane2_or_addr2, bank1_lane1_en_n, bank1_lane0_en_n;
    logic [4:0] seenSt;
    logic seenRw, act, done;
    logic [23:0] ad;
    wire [4:0] sv = {peripheral_strobe_n, bank0_lane1_en_n, bank0_lane0_en_n, bank1_lane1_en_n, bank1_lane0_en_n};
    xmb_row_t rows [0:7];
    integer n_fail = 0;
    integer n_checks = 0;
    integer i;
    xmb_bus_pins i_dut (.*);
    xmb_mem_model i_mem (.*, .strobeN(sv), .hiHalf(bank0_lane3_or_addr1 && !(bank0_lane0_en_n && bank0_lane1_en_n)));
    always #4 mclk = ~mclk;
    task check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic await(ref logic s, input logic v, input string nm);
        integer k;
        for (k = 0; k < 80 && s !== v; k++) begin
            @(posedge mclk);
            #1;
        end
        check(s, v, nm);
        if (s !== v) give_verdict;
    endtask
    task automatic access(input xmb_row_t r, input logic [3:0] w);
        integer k;
        @(posedge mclk);
        #1;
        {bank0Width, bank1Width, program_width_sel, waitCyc} = {r.wid, r.wid, r.fe, w};
        repeat (4) @(posedge mclk);
        #1;
        {reqWrite, reqFetch, reqSpace, reqSize, reqAddr, reqWdata} = {r.wr, r.fe, r.sp, r.sz, r.ad, r.wd};
        reqValid = 1'b1;
        {seenSt, seenRw, act, done, rd} = {5'h1f, 1'bx, 2'b00, 32'hx};
        ad = 24'h0;
        for (k = 0; k < 80 && !done; k++) begin
            @(posedge mclk);
            #1;
            if (sv != 5'h1f) seenRw = readWriteN;
            if (sv != 5'h1f) ad = addrOut;
            seenSt = seenSt & sv;
            done = r.wr ? (act && sv == 5'h1f) : respValid;
            act = act | (sv != 5'h1f);
            if (respValid) rd = respRdata;
            if (reqReady) reqValid = 1'b0;
        end
        check(done, 1'b1, "access done");
        if (!done) give_verdict;
        check(seenSt, r.st, "strobes");
        check(seenRw, !r.wr, "direction");
        check({8'h0, ad[23:2], 2'h0}, {8'h0, r.ad[23:2], 2'h0}, "address");
        if (!r.wr) check(rd & (r.sz == 2'h0 ? 32'hff : 32'hffffffff), r.wd, "read data");
    endtask
    initial begin
        // width, space, write, fetch, size, address, data, strobes seen
        rows[0] = '{2'h2, 2'h0, 1'b1, 1'b0, 2'h2, 24'h10, 32'ha5c30f81, 5'h13};
        rows[1] = '{2'h2, 2'h0, 1'b0, 1'b0, 2'h2, 24'h10, 32'ha5c30f81, 5'h13};
        rows[2] = '{2'h2, 2'h1, 1'b1, 1'b0, 2'h2, 24'h24, 32'h5a3cf07e, 5'h1c};
        rows[3] = '{2'h2, 2'h1, 1'b0, 1'b0, 2'h2, 24'h24, 32'h5a3cf07e, 5'h1c};
        rows[4] = '{2'h2, 2'h2, 1'b1, 1'b0, 2'h2, 24'h08, 32'h01234567, 5'h0f};
        rows[5] = '{2'h2, 2'h2, 1'b0, 1'b0, 2'h2, 24'h08, 32'h01234567, 5'h0f};
        rows[6] = '{2'h0, 2'h1, 1'b0, 1'b0, 2'h0, 24'h20, 32'h00000067, 5'h1e};
        rows[7] = '{2'h1, 2'h0, 1'b0, 1'b1, 2'h2, 24'h10, 32'h01234567, 5'h13};
        repeat (4) @(posedge mclk);
        #1;
        check({ctrlOe, addrOe, dataOe, bus_hold_ack_n}, 4'h1, "reset pins");
        resetn = 1'b1;
        for (i = 0; i < 8; i++) begin
            access(rows[i], 4'(i * 2));
        end
        #1 holdReqN = 1'b0;
        await(bus_hold_ack_n, 1'b0, "hold ack");
        check({ctrlOe, addrOe, dataOe}, 3'h0, "hold float");
        #1 {reqWrite, reqSpace, reqValid} = {1'b0, 2'h0, 1'b1};
        repeat (8) @(posedge mclk);
        check(reqReady, 1'b0, "hold refuse");
        #1 ignore_hold_bit = 1'b1;
        await(bus_hold_ack_n, 1'b1, "ignore ack");
        await(reqReady, 1'b1, "ignore take");
        #1 reqValid = 1'b0;
        await(respValid, 1'b1, "held read");
        #1 {ignore_hold_bit, holdReqN, float_all_n} = 3'b010;
        repeat (6) @(posedge mclk);
        check({ctrlOe, addrOe, dataOe}, 3'h0, "float all");
        #1 float_all_n = 1'b1;
        repeat (4) @(posedge mclk);
        #1 resetn = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check({ctrlOe, addrOe, dataOe, readWriteN}, 4'h1, "mid reset pins");
        resetn = 1'b1;
        repeat (4) @(posedge mclk);
        give_verdict;
    end
endmodule

// ===== test/xmb_mem_model.sv
// memory and peripheral model on the far side of the bus
`timescale 1ns/1ns
module xmb_mem_model (
    input  logic        mclk,
    input  logic [4:0]  strobeN,
    input  logic        ctrlOe,
    input  logic        readWriteN,
    input  logic        hiHalf,
    input  logic        dataOe,
    input  logic [31:0] dataOut,
    input  logic [3:0]  waitCyc,
    output logic        readyN = 1'b1,
    output logic [31:0] dataIn = 32'h0
);
    logic [31:0] word = 32'h0;
    logic [4:0]  cnt = 5'h0;
    wire         sel = ctrlOe && (strobeN != 5'h1f);
    wire         fire = sel && (cnt == {1'b0, waitCyc});
    always @(posedge mclk) begin
        cnt <= (!sel || cnt == waitCyc + 5'h6) ? 5'h0 : cnt + 5'h1;
        readyN <= !fire;
        if (fire && !readWriteN && dataOe) begin
            word <= dataOut;
        end
        // released bus toggles every cycle
        dataIn <= (sel && readWriteN) ? (hiHalf ? {word[15:0], word[31:16]} : word) : ~dataIn;
    end
endmodule
